// ### rtl/aisf_consts.vh
// constants for the auxiliary interrupt status flags block
`ifndef AISF_CONSTS_VH
`define AISF_CONSTS_VH

// special-function register locations
`define AISF_ADDR_FLAGS       8'ha7
`define AISF_ADDR_MASK        8'ha6
`define AISF_ADDR_SERIAL_BUF  8'h9b
`define AISF_ADDR_SLOW_CLR    8'hf8
`define AISF_ADDR_FAST_CLR    8'hf9
`define AISF_ADDR_ACCUM_LSB   8'hfa
`define AISF_ADDR_CONV_LSB    8'hfb

// reset values
`define AISF_RST_FLAGS        8'h00
`define AISF_RST_MASK         5'h00
`define AISF_RST_PEND         5'h00
`define AISF_RST_RDATA        8'h00

// field positions inside the flag and mask registers
`define AISF_BIT_ONE_HZ       7
`define AISF_BIT_ACCUM        6
`define AISF_BIT_CONV         5
`define AISF_BIT_MILLI        4
`define AISF_BIT_SERIAL_TX    3
`define AISF_SRC_LSB          3

// pending source codes, lower code wins
`define AISF_CODE_NONE        4'h0
`define AISF_CODE_SERIAL_TX   4'h4
`define AISF_CODE_MILLI       4'h5
`define AISF_CODE_CONV        4'h6
`define AISF_CODE_ACCUM       4'h7
`define AISF_CODE_ONE_HZ      4'h8

`endif

// ### rtl/aisf_flags.v
// auxiliary interrupt flag register with mask, source clears and result hold
`include "aisf_consts.vh"
`default_nettype none

module aisf_flags #(
    parameter RESULT_W = 24
) (
    input  wire                core_clk,         // system clock
    input  wire                sys_rst,          // synchronous reset, high
    input  wire [7:0]          sfr_addr,         // special-function address
    input  wire                sfr_rd,           // read strobe
    input  wire                sfr_wr,           // write strobe
    input  wire [7:0]          sfr_wdata,        // write data
    input  wire                one_hz_evt,       // seconds tick pulse
    input  wire                accum_evt,        // summation done pulse
    input  wire                conv_evt,         // conversion done pulse
    input  wire [RESULT_W-1:0] conv_data,        // new conversion value
    input  wire                millitick_evt,    // millisecond tick pulse
    input  wire                serial_tx_evt,    // transmit buffer empty pulse
    output reg  [7:0]          sfr_rdata,        // read data, next cycle
    output reg  [RESULT_W-1:0] conv_result,      // conversion result register
    output reg  [7:0]          aux_irq_flags_reg,// masked flags
    output reg  [3:0]          aux_pending_code, // highest priority pending
    output reg                 aux_irq           // any masked flag set
);

    // pending state per source; bit 0 stands for flag bit 3
    reg  [4:0] raw_pend;
    // enable bits; the low mask bits have no source here and are not kept
    reg  [4:0] aux_irq_mask_reg;
    // next-state values
    reg  [4:0] next_mask;
    reg  [4:0] masked;                  // enabled view after this edge
    reg  [3:0] next_code;
    reg  [7:0] next_rdata;
    reg        next_conv_load;          // a new result may be taken

    // per-source event, clear strobe and updated pending bit
    wire [4:0] set_vec;
    wire [4:0] clr_vec;
    wire [4:0] next_raw;

    // register accesses this block answers to
    wire       mask_wr;
    wire       rd_flags;
    wire       rd_mask;
    wire       rd_conv;

    // address match shared by all the decodes
    function hit;
        input [7:0] a;
        input [7:0] loc;
        begin
            hit = (a == loc);
        end
    endfunction

    localparam B_HZ = `AISF_BIT_ONE_HZ - `AISF_SRC_LSB;
    localparam B_AC = `AISF_BIT_ACCUM - `AISF_SRC_LSB;
    localparam B_CV = `AISF_BIT_CONV - `AISF_SRC_LSB;
    localparam B_MS = `AISF_BIT_MILLI - `AISF_SRC_LSB;
    localparam B_TX = `AISF_BIT_SERIAL_TX - `AISF_SRC_LSB;
    localparam N_SRC = `AISF_BIT_ONE_HZ - `AISF_SRC_LSB + 1;

    // location whose access clears the given source
    function [7:0] clr_loc;
        input integer idx;
        begin
            case (idx)
                B_HZ:    clr_loc = `AISF_ADDR_SLOW_CLR;
                B_AC:    clr_loc = `AISF_ADDR_ACCUM_LSB;
                B_CV:    clr_loc = `AISF_ADDR_CONV_LSB;
                B_MS:    clr_loc = `AISF_ADDR_FAST_CLR;
                default: clr_loc = `AISF_ADDR_SERIAL_BUF;
            endcase
        end
    endfunction

    // source events in flag order, one-second tick on top
    assign set_vec = {one_hz_evt, accum_evt, conv_evt, millitick_evt, serial_tx_evt};

    // one pending bit per source; an event in the clearing cycle wins, so none is lost
    genvar gi;
    generate
        for (gi = 0; gi < N_SRC; gi = gi + 1) begin : g_src
            wire clr_strobe;            // the access kind that clears this source
            // serial transmit clears on a write of its buffer, the rest on a read
            assign clr_strobe   = (gi == B_TX) ? sfr_wr : sfr_rd;
            assign clr_vec[gi]  = clr_strobe & hit(sfr_addr, clr_loc(gi));
            assign next_raw[gi] = set_vec[gi] | (raw_pend[gi] & ~clr_vec[gi]);
        end
    endgenerate

    // decodes of the strobed location; no decode writes the flag location
    assign mask_wr  = sfr_wr & hit(sfr_addr, `AISF_ADDR_MASK);
    assign rd_flags = hit(sfr_addr, `AISF_ADDR_FLAGS);
    assign rd_mask  = hit(sfr_addr, `AISF_ADDR_MASK);
    assign rd_conv  = hit(sfr_addr, `AISF_ADDR_CONV_LSB);

    // mask register; the flag register has no write path at all
    always @* begin
        next_mask = aux_irq_mask_reg;
        if (mask_wr) begin
            next_mask = sfr_wdata[7:3];
        end
    end

    // enabled view of the state that the next edge will hold
    always @* begin
        masked = next_raw & next_mask;
    end

    // priority encode; the seconds tick is checked last
    always @* begin
        if (masked[B_TX]) begin
            next_code = `AISF_CODE_SERIAL_TX;
        end else if (masked[B_MS]) begin
            next_code = `AISF_CODE_MILLI;
        end else if (masked[B_CV]) begin
            next_code = `AISF_CODE_CONV;
        end else if (masked[B_AC]) begin
            next_code = `AISF_CODE_ACCUM;
        end else if (masked[B_HZ]) begin
            next_code = `AISF_CODE_ONE_HZ;
        end else begin
            next_code = `AISF_CODE_NONE;
        end
    end

    // read mux sees the state before this cycle's updates
    always @* begin
        next_rdata = 8'h00;
        if (sfr_rd) begin
            if (rd_flags) begin
                next_rdata = {raw_pend & aux_irq_mask_reg, 3'h0};
            end else if (rd_mask) begin
                next_rdata = {raw_pend, 3'h0};
            end else if (rd_conv) begin
                next_rdata = conv_result[7:0];
            end
        end
    end

    // raw pending state; flag writes fall through with no effect
    always @(posedge core_clk) begin
        if (sys_rst) begin
            raw_pend <= `AISF_RST_PEND;
        end else begin
            raw_pend <= next_raw;
        end
    end

    // enable register
    always @(posedge core_clk) begin
        if (sys_rst) begin
            aux_irq_mask_reg <= `AISF_RST_MASK;
        end else begin
            aux_irq_mask_reg <= next_mask;
        end
    end

    // flag mirror tracks this edge's update, so it matches a read one cycle later
    always @(posedge core_clk) begin
        if (sys_rst) begin
            aux_irq_flags_reg <= `AISF_RST_FLAGS;
        end else begin
            aux_irq_flags_reg <= {masked, 3'h0};
        end
    end

    // highest pending source for the shared vector
    always @(posedge core_clk) begin
        if (sys_rst) begin
            aux_pending_code <= `AISF_CODE_NONE;
        end else begin
            aux_pending_code <= next_code;
        end
    end

    // level request, any enabled source
    always @(posedge core_clk) begin
        if (sys_rst) begin
            aux_irq <= 1'b0;
        end else begin
            aux_irq <= |masked;
        end
    end

    // read answer stands for one cycle only
    always @(posedge core_clk) begin
        if (sys_rst) begin
            sfr_rdata <= `AISF_RST_RDATA;
        end else begin
            sfr_rdata <= next_rdata;
        end
    end

    // gate on the raw bit, so a masked but unread result is still kept
    always @* begin
        next_conv_load = conv_evt & ~raw_pend[B_CV];
    end

    // result register; an unread result is never overwritten
    always @(posedge core_clk) begin
        if (sys_rst) begin
            conv_result <= {RESULT_W{1'b0}};
        end else if (next_conv_load) begin
            conv_result <= conv_data;
        end
    end

endmodule

`default_nettype wire

// ### dv/aisf_flags_props.sv
// assertions on the flag block ports
`default_nettype none
`include "aisf_consts.vh"
module aisf_flags_props #(
    parameter RESULT_W = 24
) (
    input wire logic                core_clk,          // system clock
    input wire logic                sys_rst,           // synchronous reset, high
    input wire logic                sfr_rd,            // read strobe
    input wire logic                sfr_wr,            // write strobe
    input wire logic                one_hz_evt,        // seconds tick pulse
    input wire logic                conv_evt,          // conversion done pulse
    input wire logic                aux_irq,           // any enabled flag
    input wire logic [7:0]          sfr_addr,          // strobed location
    input wire logic [7:0]          aux_irq_flags_reg, // enabled flags
    input wire logic [RESULT_W-1:0] conv_result,       // result register
    input wire logic [3:0]          aux_pending_code   // highest pending source
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    // a mask write may legally raise or drop any flag
    wire logic [7:0] f = aux_irq_flags_reg;
    wire logic mwr = sfr_wr && sfr_addr == `AISF_ADDR_MASK;
    reset_zero_a: assert property ($fell(sys_rst) |-> f == 8'h00)
        else $error("flags not zero after reset");
    low_bits_a: assert property (f[2:0] == 3'h0)
        else $error("unused flag bits set");
    irq_level_a: assert property (aux_irq == |f)
        else $error("irq disagrees with flags");
    prio_lowest_a: assert property ((aux_pending_code == 4'h8) == (f[7:3] == 5'h10))
        else $error("one-hz priority wrong");
    sec_rise_a: assert property ($rose(f[7]) |-> $past(one_hz_evt) || $past(mwr))
        else $error("one-hz flag rose without cause");
    sec_clear_a: assert property ($fell(f[7]) |-> $past(mwr)
        || $past(sfr_rd && sfr_addr == `AISF_ADDR_SLOW_CLR)) else $error("bad one-hz clear");
    ms_clear_a: assert property ($fell(f[4]) |-> $past(mwr)
        || $past(sfr_rd && sfr_addr == `AISF_ADDR_FAST_CLR)) else $error("bad milli clear");
    tx_clear_a: assert property ($fell(f[3]) |-> $past(mwr)
        || $past(sfr_wr && sfr_addr == `AISF_ADDR_SERIAL_BUF)) else $error("bad tx clear");
    conv_hold_a: assert property ($past(conv_evt) && $past(f[5]) |-> $stable(conv_result))
        else $error("unread result overwritten");
endmodule
`default_nettype wire

// ### dv/aux_interrupt_status_flags_tb.sv
// self-checking bench for the auxiliary interrupt flag block
`default_nettype none
`include "aisf_consts.vh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
module aux_interrupt_status_flags_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 0, sys_rst = 1, sfr_rd = 0, sfr_wr = 0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00;
    logic [4:0]  ev = 5'h00; // one_hz, accum, conv, milli, tx from msb
    logic [23:0] cd = 24'h0;
    wire  [7:0]  rdata, flags;
    wire  [23:0] res;
    wire  [3:0]  code;
    wire         irq;
    int          err_count = 0, num_checks = 0;
    always #5 core_clk = ~core_clk;
    aisf_flags #(.RESULT_W(24)) DUT (.core_clk(core_clk), .sys_rst(sys_rst),
        .sfr_addr(sfr_addr), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
        .one_hz_evt(ev[4]), .accum_evt(ev[3]), .conv_evt(ev[2]), .conv_data(cd),
        .millitick_evt(ev[1]), .serial_tx_evt(ev[0]), .sfr_rdata(rdata), .conv_result(res),
        .aux_irq_flags_reg(flags), .aux_pending_code(code), .aux_irq(irq));
    // one strobe cycle; answer and flag update are settled on return
    task automatic acc(input logic w, input logic [7:0] a, d);
        @(posedge core_clk);
        sfr_rd <= !w;
        sfr_wr <= w;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge core_clk);
        sfr_rd <= 1'b0;
        sfr_wr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [7:0] a, e);
        acc(1'b0, a, 8'h00);
        `CHK("rdata", e, rdata)
    endtask
    task automatic pulse(input logic [4:0] m, input logic [23:0] d);
        @(posedge core_clk);
        ev <= m;
        cd <= d;
        @(posedge core_clk);
        ev <= 5'h00;
        #1;
    endtask
    task automatic s_reset;
        rdc(`AISF_ADDR_FLAGS, 8'h00);
        rdc(`AISF_ADDR_MASK, 8'h00);
    endtask
    // all sources at once, then a second result while the first is unread
    task automatic s_events;
        acc(1'b1, `AISF_ADDR_MASK, 8'hf8);
        pulse(5'h1f, 24'h123456);
        `CHK("flags", 8'hf8, flags)
        `CHK("code", 4'h4, code)
        `CHK("irq", 1'b1, irq)
        rdc(`AISF_ADDR_MASK, 8'hf8);
        acc(1'b1, `AISF_ADDR_FLAGS, 8'h00);
        rdc(`AISF_ADDR_FLAGS, 8'hf8);
        pulse(5'h04, 24'h654321);
        `CHK("result", 24'h123456, res)
        rdc(`AISF_ADDR_CONV_LSB, 8'h56);
        `CHK("flags", 8'hd8, flags)
    endtask
    task automatic s_clears;
        acc(1'b0, `AISF_ADDR_SLOW_CLR, 8'h00);
        `CHK("flags", 8'h58, flags)
        acc(1'b0, `AISF_ADDR_FAST_CLR, 8'h00);
        `CHK("flags", 8'h48, flags)
        acc(1'b0, `AISF_ADDR_ACCUM_LSB, 8'h00);
        `CHK("flags", 8'h08, flags)
        acc(1'b1, `AISF_ADDR_SERIAL_BUF, 8'h00);
        `CHK("irq", 1'b0, irq)
        pulse(5'h04, 24'h654321);
        `CHK("result", 24'h654321, res)
        rdc(`AISF_ADDR_CONV_LSB, 8'h21);
    endtask
    task automatic s_masked;
        acc(1'b1, `AISF_ADDR_MASK, 8'h00);
        pulse(5'h10, 24'h0);
        `CHK("flags", 8'h00, flags)
        rdc(`AISF_ADDR_MASK, 8'h80);
        acc(1'b1, `AISF_ADDR_MASK, 8'h80);
        `CHK("code", 4'h8, code)
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // a hang counts as a mismatch
    initial begin
        #100000;
        err_count++;
        give_verdict;
    end
    initial begin
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        s_reset;
        s_events;
        s_clears;
        s_masked;
        give_verdict;
    end
endmodule
bind aisf_flags aisf_flags_props #(.RESULT_W(RESULT_W)) u_props (.core_clk(core_clk),
    .sys_rst(sys_rst), .sfr_rd(sfr_rd), .sfr_wr(sfr_wr), .one_hz_evt(one_hz_evt),
    .conv_evt(conv_evt), .aux_irq(aux_irq), .sfr_addr(sfr_addr), .conv_result(conv_result),
    .aux_irq_flags_reg(aux_irq_flags_reg), .aux_pending_code(aux_pending_code));
`default_nettype wire
